/* File: rtl/hmacc_consts.svh */
`ifndef HMACC_CONSTS_SVH
`define HMACC_CONSTS_SVH

// Register byte offsets.
`define HM_ADDR_CTRL     16'h0000
`define HM_ADDR_PRE_HRS  16'h0004
`define HM_ADDR_PRE_MIN  16'h0008
`define HM_ADDR_PRE_SEC  16'h000C
`define HM_ADDR_DSTART   16'h0010
`define HM_ADDR_STATUS   16'h0014
`define HM_ADDR_ACC_HRS  16'h0018
`define HM_ADDR_ACC_MIN  16'h001C
`define HM_ADDR_ACC_SEC  16'h0020
`define HM_DWIN_BASE     16'h4000

// Control field positions and reset values.
`define HM_CTRL_MODE     0
`define HM_CTRL_SRC      1
`define HM_MODE_RST      1'h0
`define HM_SRC_RST       1'h0

// Status field positions.
`define HM_ST_OUT        0
`define HM_ST_ERR        1
`define HM_ST_ERR_STICKY 2
`define HM_ST_EXEC       3
`define HM_ST_START_BAD  4

// Value limits.
`define HM_ROLL          6'h3B
`define HM_FIELD_MAX     16'h003B
`define HM_HRS_TOP       16'hFFFF
`define HM_DSTART_LO_MAX 16'h03E5
`define HM_DSTART_HI_MIN 16'h03E8
`define HM_DSTART_HI_MAX 16'h07CD
`define HM_DWORDS        32'h0000_0002

// Timing: one second of on-time, clock period 10 ns.
`define HM_TICK_NS       1000000000
`define HM_CLK_NS        10

`endif

/* File: rtl/hmacc_pkg.sv */
package hmacc_pkg;

    typedef enum logic [1:0] {
        SLOT_HOURS,
        SLOT_MIN,
        SLOT_SEC
    } hmacc_slot_e;

    typedef logic [15:0] hmacc_word_t;

endpackage

/* File: rtl/hmacc_dreg_ram.sv */
`timescale 1ns/100ps

module hmacc_dreg_ram #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 2000,
    parameter int unsigned AW    = 11
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // Write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read port
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en && (32'(wr_addr) < DEPTH)) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= '0;
        end else if (32'(rd_addr) < DEPTH) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= '0;
        end
    end

endmodule

/* File: rtl/hmacc_top.sv */
`timescale 1ns/100ps
`include "hmacc_consts.svh"

// Summary of operation
// - Count on-time while execute high, clear low.
// - No counting while clear is high.
// - Clear wins: total zero, output low.
// - Unused clear input reads as low.
// - Output high when total reaches preset.
// - Constant preset: hours, minutes, seconds slots.
// - Indirect preset from three consecutive data words.
// - Keep mode holds output while execute low, until clear or a bad preset; with execute high it follows the compare.
// - Clear mode drops output when execute drops.
// - Total kept while execute low, then resumes.
// - Hours wrap past 65535:59:59.
// - Bad preset flags error, output low, counting continues.
module hmacc_top
    import hmacc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `HM_TICK_NS / `HM_CLK_NS,
    parameter int unsigned DEPTH       = 2000,
    parameter bit          CLEAR_USED  = 1'b1
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Block pins
    input  wire logic        exec_in,
    input  wire logic        clear_in,
    output logic             cmp_out,
    output logic             exec_error
);

    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    logic [1:0]        pin_meta;
    logic [1:0]        pin_sync;
    logic              exec_s;
    logic              clear_s;
    logic [TW-1:0]     presc;
    logic              tick;
    logic [5:0]        acc_sec;
    logic [5:0]        acc_min;
    hmacc_word_t       acc_hrs;
    logic              mode_clear;
    logic              src_ind;
    hmacc_word_t       const_h;
    hmacc_word_t       const_m;
    hmacc_word_t       const_s;
    hmacc_word_t       ind_h;
    hmacc_word_t       ind_m;
    hmacc_word_t       ind_s;
    hmacc_word_t       dstart;
    hmacc_word_t       pre_h;
    hmacc_word_t       pre_m;
    hmacc_word_t       pre_s;
    logic              start_bad;
    logic              err_cfg;
    logic              err_sticky;
    logic              ge;
    hmacc_slot_e       fetch_idx;
    hmacc_slot_e       fetch_slot;
    logic              fetch_vld;
    logic [AW-1:0]     fetch_addr;
    logic [AW-1:0]     mem_rd_addr;
    hmacc_word_t       mem_rd_data;
    logic              mem_issued;
    logic              apb_mem_rd;
    logic [15:0]       win_off;
    logic [AW-1:0]     mem_idx;
    logic              is_data;
    logic              reg_hit;
    logic [31:0]       reg_val;
    logic              wr_done;
    logic              next_cmp;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // Pins pass two flip-flops before use.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
        end else begin
            pin_meta <= {clear_in, exec_in};
            pin_sync <= pin_meta;
        end
    end

    assign exec_s  = pin_sync[0];
    assign clear_s = CLEAR_USED ? pin_sync[1] : 1'b0;

    // Sub-second progress is kept while execute is low, so short pulses still add up.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            presc <= '0;
        end else if (clear_s) begin
            presc <= '0;
        end else if (exec_s) begin
            presc <= tick ? '0 : presc + 1'b1;
        end
    end

    assign tick = exec_s && !clear_s && (presc == TICK_LAST);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            acc_sec <= '0;
            acc_min <= '0;
            acc_hrs <= '0;
        end else if (clear_s) begin
            acc_sec <= '0;
            acc_min <= '0;
            acc_hrs <= '0;
        end else if (tick) begin
            if (acc_sec == `HM_ROLL) begin
                acc_sec <= '0;
                if (acc_min == `HM_ROLL) begin
                    acc_min <= '0;
                    acc_hrs <= acc_hrs + 1'b1;
                end else begin
                    acc_min <= acc_min + 1'b1;
                end
            end else begin
                acc_sec <= acc_sec + 1'b1;
            end
        end
    end

    // Preset selection and range checks.
    assign pre_h = src_ind ? ind_h : const_h;
    assign pre_m = src_ind ? ind_m : const_m;
    assign pre_s = src_ind ? ind_s : const_s;

    assign start_bad = ((dstart > `HM_DSTART_LO_MAX) && ((dstart < `HM_DSTART_HI_MIN)
                       || (dstart > `HM_DSTART_HI_MAX)))
                       || (({16'h0000, dstart} + `HM_DWORDS) >= DEPTH);
    assign err_cfg   = (pre_m > `HM_FIELD_MAX) || (pre_s > `HM_FIELD_MAX)
                       || (src_ind && start_bad);
    assign ge        = {acc_hrs, acc_min, acc_sec} >= {pre_h, pre_m[5:0], pre_s[5:0]};

    always_comb begin
        if (clear_s || err_cfg) begin
            next_cmp = 1'b0;
        end else if (mode_clear) begin
            next_cmp = exec_s && ge;
        end else begin
            next_cmp = exec_s ? ge : (cmp_out || ge);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmp_out    <= 1'b0;
            exec_error <= 1'b0;
        end else begin
            cmp_out    <= next_cmp;
            exec_error <= err_cfg;
        end
    end

    // Indirect preset fetch: walks the three words in turn, yielding to APB data-window reads.
    // Words are only taken while the indirect source is selected; with the constant source the last fetched words are held.
    always_comb begin
        unique case (fetch_idx)
            SLOT_HOURS: fetch_addr = AW'(dstart);
            SLOT_MIN:   fetch_addr = AW'(dstart) + AW'(1);
            SLOT_SEC:   fetch_addr = AW'(dstart) + AW'(2);
            default:    fetch_addr = AW'(dstart);
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fetch_idx  <= SLOT_HOURS;
            fetch_slot <= SLOT_HOURS;
            fetch_vld  <= 1'b0;
        end else begin
            fetch_vld  <= !apb_mem_rd && src_ind;
            fetch_slot <= fetch_idx;
            if (!apb_mem_rd) begin
                unique case (fetch_idx)
                    SLOT_HOURS: fetch_idx <= SLOT_MIN;
                    SLOT_MIN:   fetch_idx <= SLOT_SEC;
                    SLOT_SEC:   fetch_idx <= SLOT_HOURS;
                    default:    fetch_idx <= SLOT_HOURS;
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ind_h <= '0;
            ind_m <= '0;
            ind_s <= '0;
        end else if (fetch_vld) begin
            unique case (fetch_slot)
                SLOT_HOURS: ind_h <= mem_rd_data;
                SLOT_MIN:   ind_m <= mem_rd_data;
                SLOT_SEC:   ind_s <= mem_rd_data;
                default:    ind_h <= ind_h;
            endcase
        end
    end

    // APB decode.
    assign win_off    = paddr - `HM_DWIN_BASE;
    assign mem_idx    = win_off[AW+1:2];
    assign is_data    = (paddr >= `HM_DWIN_BASE) && (32'(win_off[15:2]) < DEPTH) && (win_off[1:0] == 2'h0);
    assign apb_mem_rd = psel && penable && !pwrite && is_data && !pready && !mem_issued;
    assign mem_rd_addr = apb_mem_rd ? mem_idx : fetch_addr;
    assign wr_done    = psel && penable && pready && pwrite;

    always_comb begin
        reg_hit = 1'b1;
        reg_val = 32'h0000_0000;
        case (paddr)
            `HM_ADDR_CTRL: begin
                reg_val[`HM_CTRL_MODE] = mode_clear;
                reg_val[`HM_CTRL_SRC]  = src_ind;
            end
            `HM_ADDR_PRE_HRS: reg_val = {16'h0000, const_h};
            `HM_ADDR_PRE_MIN: reg_val = {16'h0000, const_m};
            `HM_ADDR_PRE_SEC: reg_val = {16'h0000, const_s};
            `HM_ADDR_DSTART:  reg_val = {16'h0000, dstart};
            `HM_ADDR_STATUS: begin
                reg_val[`HM_ST_OUT]        = cmp_out;
                reg_val[`HM_ST_ERR]        = err_cfg;
                reg_val[`HM_ST_ERR_STICKY] = err_sticky;
                reg_val[`HM_ST_EXEC]       = exec_s;
                reg_val[`HM_ST_START_BAD]  = start_bad;
            end
            `HM_ADDR_ACC_HRS: reg_val = {16'h0000, acc_hrs};
            `HM_ADDR_ACC_MIN: reg_val = {26'h000_0000, acc_min};
            `HM_ADDR_ACC_SEC: reg_val = {26'h000_0000, acc_sec};
            default: begin
                reg_hit = 1'b0;
            end
        endcase
    end

    // Register reads answer one cycle into the access phase, data-window reads two.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= 32'h0000_0000;
            mem_issued <= 1'b0;
        end else if (pready) begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            mem_issued <= 1'b0;
        end else if (psel && penable) begin
            if (apb_mem_rd) begin
                mem_issued <= 1'b1;
            end else begin
                pready  <= 1'b1;
                pslverr <= !(is_data || reg_hit);
                if (pwrite) begin
                    prdata <= 32'h0000_0000;
                end else if (is_data) begin
                    prdata <= {16'h0000, mem_rd_data};
                end else begin
                    prdata <= reg_val;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mode_clear <= `HM_MODE_RST;
            src_ind    <= `HM_SRC_RST;
            const_h    <= '0;
            const_m    <= '0;
            const_s    <= '0;
            dstart     <= '0;
        end else if (wr_done) begin
            case (paddr)
                `HM_ADDR_CTRL: begin
                    mode_clear <= pwdata[`HM_CTRL_MODE];
                    src_ind    <= pwdata[`HM_CTRL_SRC];
                end
                `HM_ADDR_PRE_HRS: const_h <= pwdata[15:0];
                `HM_ADDR_PRE_MIN: const_m <= pwdata[15:0];
                `HM_ADDR_PRE_SEC: const_s <= pwdata[15:0];
                `HM_ADDR_DSTART:  dstart  <= pwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // A new error in the clearing cycle keeps the flag set.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            err_sticky <= 1'b0;
        end else if (err_cfg) begin
            err_sticky <= 1'b1;
        end else if (wr_done && (paddr == `HM_ADDR_STATUS) && pwdata[`HM_ST_ERR_STICKY]) begin
            err_sticky <= 1'b0;
        end
    end

    hmacc_dreg_ram #(
        .WIDTH (16),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_dreg (
        .clock   (clock),
        .rst_b   (rst_b),
        .wr_en   (wr_done && is_data),
        .wr_addr (mem_idx),
        .wr_data (pwdata[15:0]),
        .rd_addr (mem_rd_addr),
        .rd_data (mem_rd_data)
    );

    sequence s_sec_roll;
        tick && (acc_sec == `HM_ROLL);
    endsequence

    sequence s_out_idle_keep;
        cmp_out && !exec_s && !clear_s && !mode_clear && !err_cfg;
    endsequence

    clr_forces_zero_a: assert property (clear_s |=> (acc_sec == 6'h00) && (acc_min == 6'h00)
        && (acc_hrs == 16'h0000) && !cmp_out) else $error("clear did not zero the total");
    clr_stops_presc_a: assert property (clear_s |=> (presc == '0) && !tick)
        else $error("prescaler ran during clear");
    tick_adds_sec_a: assert property (tick && (acc_sec != `HM_ROLL) && !clear_s
        |=> acc_sec == $past(acc_sec) + 6'h01) else $error("second not added on tick");
    idle_keeps_total_a: assert property (!exec_s && !clear_s
        |=> $stable(acc_hrs) && $stable(acc_min) && $stable(acc_sec)) else $error("total moved while idle");
    sec_carry_a: assert property (s_sec_roll and (acc_min != `HM_ROLL)
        |=> (acc_sec == 6'h00) && (acc_min == $past(acc_min) + 6'h01)) else $error("seconds carry wrong");
    hrs_wrap_a: assert property (s_sec_roll and (acc_min == `HM_ROLL) && (acc_hrs == `HM_HRS_TOP)
        |=> acc_hrs == 16'h0000) else $error("hours did not wrap");
    out_on_reach_a: assert property (exec_s && !clear_s && !err_cfg && ge |=> cmp_out)
        else $error("output low at preset");
    keep_holds_a: assert property (s_out_idle_keep |=> cmp_out)
        else $error("keep mode dropped output");
    clear_mode_drop_a: assert property (mode_clear && !exec_s |=> !cmp_out)
        else $error("clear mode kept output");
    err_out_low_a: assert property (err_cfg |=> !cmp_out && exec_error)
        else $error("error did not force output low");
    fetch_hours_a: assert property (fetch_vld && (fetch_slot == SLOT_HOURS)
        |=> ind_h == $past(mem_rd_data)) else $error("hours word not fetched");

endmodule

/* File: verif/hmacc_prog_model.sv */
`timescale 1ns/100ps

module hmacc_prog_model (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // Requests from the bench
    input  wire logic run_req,
    input  wire logic wipe_req,
    // Block pins
    output logic      exec_in,
    output logic      clear_in
);
    // Program logic settles its outputs once per scan, on the clock edge.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            exec_in  <= 1'b0;
            clear_in <= 1'b0;
        end else begin
            exec_in  <= run_req;
            clear_in <= wipe_req;
        end
    end
endmodule

/* File: verif/hour_meter_accumulator_tb.sv */
`timescale 1ns/100ps
`include "hmacc_consts.svh"

module hour_meter_accumulator_tb;
    import hmacc_pkg::*;
    localparam int unsigned TICK = 5;
    logic        clock;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        exec_in;
    logic        clear_in;
    logic        cmp_out;
    logic        exec_error;
    logic        run_req;
    logic        wipe_req;
    logic        nc_out;
    hmacc_word_t rnd_hrs;
    hmacc_word_t rnd_min;
    logic [32:0] expq[$];
    string       nameq[$];
    int          n_mismatch;
    int          tests_run;

    hmacc_top #(.TICK_CYCLES(TICK), .DEPTH(2000), .CLEAR_USED(1'b1)) dut_u (
        .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .exec_in(exec_in), .clear_in(clear_in), .cmp_out(cmp_out), .exec_error(exec_error));

    // Clear pin left unused: held high here, it must still read as low.
    hmacc_top #(.TICK_CYCLES(TICK), .DEPTH(2000), .CLEAR_USED(1'b0)) dut_nc_u (
        .clock(clock), .rst_b(rst_b), .psel(1'b0), .penable(1'b0), .pwrite(1'b0),
        .paddr(16'h0000), .pwdata(32'h0000_0000), .prdata(), .pready(), .pslverr(),
        .exec_in(exec_in), .clear_in(1'b1), .cmp_out(nc_out), .exec_error());

    hmacc_prog_model prog_u (
        .clock(clock), .rst_b(rst_b), .run_req(run_req), .wipe_req(wipe_req),
        .exec_in(exec_in), .clear_in(clear_in));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic pin(input string nm, input logic e, input logic g);
        cmp(nm, {32'h0000_0000, e}, {32'h0000_0000, g});
    endtask

    // The request is held until pready is sampled high, then released.
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [32:0] e, input string nm);
        expq.push_back(e);
        nameq.push_back(nm);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // On-time of the pin equals cyc cycles; six trailing cycles let the pin settle low before the next step.
    task automatic run_for(input int cyc);
        run_req <= 1'b1;
        repeat (cyc) @(posedge clock);
        run_req <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    task automatic done_test(input string nm);
        $display("test %s finished", nm);
    endtask

    // Read answers are checked here against the oldest note.
    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (expq.size() == 0) begin
                n_mismatch++;
                $display("wrong value read note expected one seen none");
            end else begin
                cmp(nameq.pop_front(), expq.pop_front(), {pslverr, prdata});
            end
        end
    end

    task automatic wrap_up;
        if (expq.size() != 0) begin
            n_mismatch++;
            $display("wrong value read note expected none seen %0d", expq.size());
        end
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        $display("wrong value watchdog expected finish seen hang");
        wrap_up();
    end

    initial begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 16'h0000; pwdata = 32'h0000_0000; run_req = 1'b0; wipe_req = 1'b0;
        void'($urandom(33));
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        rnd_hrs = hmacc_word_t'($urandom);
        rnd_min = hmacc_word_t'($urandom_range(59));
        rd(`HM_ADDR_CTRL, 33'h0_0000_0000, "ctrl");
        rd(`HM_ADDR_STATUS, 33'h0_0000_0001, "status");
        rd(16'h0100, 33'h1_0000_0000, "unmapped");
        apb(1'b1, `HM_ADDR_PRE_HRS, {16'h0000, rnd_hrs});
        apb(1'b1, `HM_ADDR_PRE_MIN, {16'h0000, rnd_min});
        rd(`HM_ADDR_PRE_HRS, {17'h0_0000, rnd_hrs}, "pre_hrs");
        rd(`HM_ADDR_PRE_MIN, {17'h0_0000, rnd_min}, "pre_min");
        done_test("reset");
        apb(1'b1, `HM_ADDR_PRE_HRS, 32'h0000_0000);
        apb(1'b1, `HM_ADDR_PRE_MIN, 32'h0000_0001);
        apb(1'b1, `HM_ADDR_PRE_SEC, 32'h0000_0002);
        run_for(61 * TICK + 2);
        rd(`HM_ADDR_ACC_MIN, 33'h0_0000_0001, "acc_min");
        rd(`HM_ADDR_ACC_SEC, 33'h0_0000_0001, "acc_sec");
        rd(`HM_ADDR_STATUS, 33'h0_0000_0000, "status");
        run_for(TICK);
        rd(`HM_ADDR_STATUS, 33'h0_0000_0001, "status");
        pin("cmp_out", 1'b1, cmp_out);
        done_test("count");
        apb(1'b1, `HM_ADDR_CTRL, 32'h0000_0001);
        rd(`HM_ADDR_STATUS, 33'h0_0000_0000, "status");
        run_req <= 1'b1;
        repeat (6) @(posedge clock);
        pin("cmp_out", 1'b1, cmp_out);
        run_req <= 1'b0;
        repeat (6) @(posedge clock);
        pin("cmp_out", 1'b0, cmp_out);
        done_test("modes");
        run_req  <= 1'b1;
        wipe_req <= 1'b1;
        repeat (20) @(posedge clock);
        rd(`HM_ADDR_ACC_SEC, 33'h0_0000_0000, "acc_sec");
        rd(`HM_ADDR_ACC_MIN, 33'h0_0000_0000, "acc_min");
        pin("cmp_out", 1'b0, cmp_out);
        pin("nc_cmp_out", 1'b1, nc_out);
        run_req  <= 1'b0;
        wipe_req <= 1'b0;
        repeat (6) @(posedge clock);
        done_test("clear");
        run_for(3 * TICK + 1);
        rd(`HM_ADDR_ACC_SEC, 33'h0_0000_0003, "acc_sec");
        run_for(2 * TICK + 1);
        rd(`HM_ADDR_ACC_SEC, 33'h0_0000_0005, "acc_sec");
        done_test("resume");
        apb(1'b1, `HM_ADDR_CTRL, 32'h0000_0000);
        apb(1'b1, `HM_ADDR_PRE_SEC, 32'h0000_003C);
        rd(`HM_ADDR_STATUS, 33'h0_0000_0006, "status");
        pin("exec_error", 1'b1, exec_error);
        run_for(2 * TICK + 2);
        rd(`HM_ADDR_ACC_SEC, 33'h0_0000_0007, "acc_sec");
        apb(1'b1, `HM_ADDR_PRE_SEC, 32'h0000_0000);
        apb(1'b1, `HM_ADDR_STATUS, 32'h0000_0004);
        rd(`HM_ADDR_STATUS, 33'h0_0000_0000, "status");
        done_test("error");
        apb(1'b1, `HM_DWIN_BASE + 16'h0FA0, 32'h0000_0000);
        apb(1'b1, `HM_DWIN_BASE + 16'h0FA4, 32'h0000_0000);
        apb(1'b1, `HM_DWIN_BASE + 16'h0FA8, 32'h0000_0006);
        apb(1'b1, `HM_DWIN_BASE + 16'h0F98, 32'h0000_0000);
        apb(1'b1, `HM_DWIN_BASE + 16'h0F9C, 32'h0000_0000);
        rd(`HM_DWIN_BASE + 16'h0FA8, 33'h0_0000_0006, "data_word");
        apb(1'b1, `HM_ADDR_DSTART, 32'h0000_03E8);
        apb(1'b1, `HM_ADDR_CTRL, 32'h0000_0002);
        repeat (10) @(posedge clock);
        rd(`HM_ADDR_STATUS, 33'h0_0000_0001, "status");
        apb(1'b1, `HM_ADDR_DSTART, 32'h0000_03E6);
        repeat (10) @(posedge clock);
        rd(`HM_ADDR_STATUS, 33'h0_0000_0016, "status");
        pin("exec_error", 1'b1, exec_error);
        done_test("indirect");
        repeat (4) @(posedge clock);
        wrap_up();
    end
endmodule
